// ===== src/bbsc_pkg.sv
// Shared constants and types for the buck-boost switch controller.
package bbsc_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned FSW_MIN_HZ     = 200_000;
  localparam int unsigned FSW_MAX_HZ     = 1_000_000;
  localparam logic [8:0]  HALF_MAX       = 9'(CLK_HZ / (2 * FSW_MIN_HZ));
  localparam logic [8:0]  HALF_MIN       = 9'(CLK_HZ / (2 * FSW_MAX_HZ));
  localparam int unsigned DEAD_TIME_NS   = 20;
  localparam logic [3:0]  DEAD_CYC       = 4'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned VREF_STEP_MV   = 10;
  localparam int unsigned VREF_MIN_MV    = 500;
  localparam int unsigned VREF_MAX_MV    = 2000;
  localparam logic [7:0]  VREF_MIN       = 8'(VREF_MIN_MV / VREF_STEP_MV);
  localparam logic [7:0]  VREF_MAX       = 8'(VREF_MAX_MV / VREF_STEP_MV);
  localparam logic [7:0]  REG_FBCOMP_ADDR = 8'h0d;
  localparam int unsigned FBCOMP_EXT_BIT = 1;
  localparam logic [7:0]  FBCOMP_RST     = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_PRECHARGE = 4'h2,
    ST_SOFTSTART = 4'h4,
    ST_RUN       = 4'h8
  } seq_e;

  typedef enum logic [2:0] {
    RG_BOOST     = 3'h1,
    RG_BUCKBOOST = 3'h2,
    RG_BUCK      = 3'h4
  } region_e;
endpackage

// ===== src/buck_boost_switch_control.sv
// Top of the four-switch buck-boost controller: sequencing, regions, clocking and switch timing.
// Operation
// RULE1: Boost holds input high on, input low off.
// RULE2: Boost output low switch gets fixed on time.
// RULE3: Buck holds output high on, output low off.
// RULE4: Buck-boost output low starts with input high.
// RULE5: Region chosen from sensed input versus output voltage.
// RULE6: Falling input steps buck, buck-boost, boost in order.
// RULE7: Separate rising and falling thresholds give hysteresis.
// RULE8: Pre-charge turns both low switches on.
// RULE9: Current limit during pre-charge turns low switches off.
// RULE10: Soft start only after bootstrap voltage is ready.
// RULE11: Bit one of register 0x0d selects external feedback.
// RULE12: Switching frequency programmable from 200kHz to 1MHz.
// RULE13: External sync clock 250kHz-1MHz, 20% faster.
// RULE14: Discontinuous conduction lets loop set cycle rate.
// RULE15: Sync output drives internal clock, 0 or 180 degrees.
// RULE16: Sync output clock always has 50% duty; spread spectrum steps can make one half a cycle longer.
// RULE17: Spread spectrum is symmetric triangular, programmable range/period.
// RULE18: Each modulation period sweeps min, max, min; the code starts at max and sweeps max, min, max.
// RULE19: Sync input mode disables spread spectrum.
// RULE20: Discontinuous mode turns rectifier off at zero current.
// RULE21: Forced continuous rectifier off only at reverse limit.
// RULE22: Soft start ramps reference up from zero.
// RULE23: Reference setpoint 0.5V to 2.0V in 10mV.
// RULE24: Reference moves 10mV per programmable step interval.
// RULE25: Dead time between switches of one leg.
`timescale 1ns/1ps
module buck_boost_switch_control (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  input_ok,
  input  wire logic                  supply_ok,
  input  wire logic                  enable,
  input  wire logic [11:0]           vin_sense,
  input  wire logic [11:0]           vout_sense,
  input  wire logic signed [12:0]    bb_rise_off,
  input  wire logic signed [12:0]    bb_fall_off,
  input  wire logic signed [12:0]    buck_rise_off,
  input  wire logic signed [12:0]    buck_fall_off,
  input  wire logic [8:0]            half_period,
  input  wire logic                  sync_in_mode,
  input  wire logic                  sync_out_mode,
  input  wire logic                  sync_phase_180,
  input  wire logic                  sync_in,
  output logic                       sync_out,
  output logic                       sync_oe,
  input  wire logic                  spread_spectrum_en,
  input  wire logic [5:0]            spread_spectrum_range,
  input  wire logic [15:0]           spread_spectrum_interval,
  input  wire logic                  discontinuous_conduction,
  input  wire logic                  loop_set,
  input  wire logic                  zero_current,
  input  wire logic                  reverse_limit,
  input  wire logic                  current_limit,
  input  wire logic                  input_bootstrap_ok,
  input  wire logic                  output_bootstrap_ok,
  input  wire logic [9:0]            on_cycles,
  input  wire logic [9:0]            bb_duty_cycles,
  input  wire logic [7:0]            vref_target,
  input  wire logic [15:0]           softstart_interval,
  input  wire logic [15:0]           vref_step_interval,
  output logic                       input_high_switch,
  output logic                       input_low_switch,
  output logic                       output_low_switch,
  output logic                       output_high_switch,
  output logic [7:0]                 vref_code,
  output bbsc_pkg::region_e          region,
  output logic                       precharge_active,
  output logic                       external_feedback_sel
);
  typedef struct packed {
    bbsc_pkg::seq_e    seq;
    bbsc_pkg::region_e region;
    logic [7:0]        fbcomp;
    logic [7:0]        rdata;
    logic [2:0]        sync_ff;
    logic              sync_lvl;
    logic [8:0]        half_cnt;
    logic              phase;
    logic              sync_o;
    logic signed [6:0] ss_off;
    logic              ss_up;
    logic [15:0]       ss_tmr;
    logic [9:0]        on_cnt;
    logic [9:0]        bb_cnt;
    logic              rect;
    logic [7:0]        vref;
    logic [15:0]       vref_tmr;
  } state_s;

  state_s s_q;
  state_s s_d;

  leg_if in_leg ();
  leg_if out_leg ();

  leg_driver u_in_leg (
    .clk  (clk),
    .srst (srst),
    .leg  (in_leg.drv)
  );

  leg_driver u_out_leg (
    .clk  (clk),
    .srst (srst),
    .leg  (out_leg.drv)
  );

  logic               all_ok;
  logic signed [12:0] diff;
  logic [8:0]         half_cl;
  logic               ss_active;
  logic signed [6:0]  ss_range;
  logic signed [6:0]  ss_eff;
  logic [9:0]         tgt_w;
  logic [8:0]         tgt;
  logic               stable;
  logic               sync_edge;
  logic               tick;
  logic               switching;
  logic               cycle_start;
  logic               main_on;
  logic [7:0]         vtgt;
  logic [15:0]        step_int;

  always_comb begin
    s_d = s_q;
    all_ok = input_ok && supply_ok && enable;

    // Register port.
    if (reg_wr && reg_addr == bbsc_pkg::REG_FBCOMP_ADDR) begin
      s_d.fbcomp = reg_wdata; // RULE11
    end
    s_d.rdata = (reg_addr == bbsc_pkg::REG_FBCOMP_ADDR) ? s_q.fbcomp : 8'h00;

    // Region selection with hysteresis, one region per clock.
    diff = $signed({1'b0, vin_sense}) - $signed({1'b0, vout_sense}); // RULE5
    case (s_q.region)
      bbsc_pkg::RG_BOOST: begin
        if (diff > bb_rise_off) begin
          s_d.region = bbsc_pkg::RG_BUCKBOOST; // RULE5 RULE7
        end
      end
      bbsc_pkg::RG_BUCKBOOST: begin
        if (diff > buck_rise_off) begin
          s_d.region = bbsc_pkg::RG_BUCK; // RULE5 RULE7
        end else if (diff < bb_fall_off) begin
          s_d.region = bbsc_pkg::RG_BOOST; // RULE6 RULE7
        end
      end
      bbsc_pkg::RG_BUCK: begin
        if (diff < buck_fall_off) begin
          s_d.region = bbsc_pkg::RG_BUCKBOOST; // RULE6 RULE7
        end
      end
      default: begin
        s_d.region = bbsc_pkg::RG_BOOST;
      end
    endcase

    // Sync pin conditioning.
    s_d.sync_ff = {s_q.sync_ff[1:0], sync_in};
    stable = (s_q.sync_ff[1] == s_q.sync_ff[2]);
    if (stable) begin
      s_d.sync_lvl = s_q.sync_ff[2];
    end
    sync_edge = stable && s_q.sync_ff[2] && !s_q.sync_lvl;

    // Spread spectrum triangle.
    ss_active = spread_spectrum_en && !sync_in_mode; // RULE19
    ss_range  = $signed({1'b0, spread_spectrum_range});
    ss_eff    = ss_active ? s_q.ss_off : 7'sh00;
    if (!ss_active) begin
      s_d.ss_off = ss_range; // RULE18
      s_d.ss_up  = 1'b0;
      s_d.ss_tmr = 16'h0000;
    end else if (s_q.ss_tmr >= spread_spectrum_interval) begin
      s_d.ss_tmr = 16'h0000; // RULE17
      if (s_q.ss_up) begin
        if (s_q.ss_off >= ss_range) begin
          s_d.ss_up = 1'b0; // RULE18
        end else begin
          s_d.ss_off = s_q.ss_off + 7'sh01;
        end
      end else begin
        if (s_q.ss_off <= -ss_range) begin
          s_d.ss_up = 1'b1; // RULE18
        end else begin
          s_d.ss_off = s_q.ss_off - 7'sh01;
        end
      end
    end else begin
      s_d.ss_tmr = s_q.ss_tmr + 16'h0001;
    end

    // Internal switching clock.
    if (half_period < bbsc_pkg::HALF_MIN) begin
      half_cl = bbsc_pkg::HALF_MIN; // RULE12
    end else if (half_period > bbsc_pkg::HALF_MAX) begin
      half_cl = bbsc_pkg::HALF_MAX; // RULE12
    end else begin
      half_cl = half_period;
    end
    tgt_w = {1'b0, half_cl} + {{3{ss_eff[6]}}, ss_eff}; // RULE17
    tgt   = tgt_w[8:0];
    tick  = 1'b0;
    if (sync_in_mode) begin
      s_d.half_cnt = 9'h000;
      s_d.phase    = 1'b0;
      tick         = sync_edge; // RULE13
    end else if (s_q.half_cnt >= tgt - 9'h001) begin
      s_d.half_cnt = 9'h000;
      s_d.phase    = !s_q.phase; // RULE16
      tick         = s_q.phase;
    end else begin
      s_d.half_cnt = s_q.half_cnt + 9'h001;
    end
    s_d.sync_o = !s_d.phase ^ sync_phase_180; // RULE15

    // Switching cycle timing.
    switching   = (s_q.seq == bbsc_pkg::ST_SOFTSTART) || (s_q.seq == bbsc_pkg::ST_RUN);
    cycle_start = switching && (discontinuous_conduction ? loop_set : tick); // RULE14
    main_on     = s_q.on_cnt != 10'h000;
    if (!switching) begin
      s_d.on_cnt = 10'h000;
      s_d.bb_cnt = 10'h000;
      s_d.rect   = 1'b0;
    end else if (cycle_start) begin
      s_d.on_cnt = (on_cycles == 10'h000) ? 10'h001 : on_cycles; // RULE2
      s_d.bb_cnt = bb_duty_cycles; // RULE4
      s_d.rect   = 1'b1;
    end else begin
      if (main_on) begin
        s_d.on_cnt = s_q.on_cnt - 10'h001;
      end
      if (s_q.bb_cnt != 10'h000) begin
        s_d.bb_cnt = s_q.bb_cnt - 10'h001;
      end
      if (!main_on && s_q.rect) begin
        if (discontinuous_conduction ? zero_current : reverse_limit) begin
          s_d.rect = 1'b0; // RULE20 RULE21
        end
      end
    end

    // Sequencer and reference.
    if (vref_target < bbsc_pkg::VREF_MIN) begin
      vtgt = bbsc_pkg::VREF_MIN; // RULE23
    end else if (vref_target > bbsc_pkg::VREF_MAX) begin
      vtgt = bbsc_pkg::VREF_MAX; // RULE23
    end else begin
      vtgt = vref_target;
    end
    step_int = (s_q.seq == bbsc_pkg::ST_SOFTSTART) ? softstart_interval : vref_step_interval;
    if (switching) begin
      if (s_q.vref == vtgt) begin
        s_d.vref_tmr = 16'h0000;
      end else if (s_q.vref_tmr >= step_int) begin
        s_d.vref_tmr = 16'h0000; // RULE24
        if (s_q.vref < vtgt) begin
          s_d.vref = s_q.vref + 8'h01; // RULE22 RULE24
        end else begin
          s_d.vref = s_q.vref - 8'h01; // RULE24
        end
      end else begin
        s_d.vref_tmr = s_q.vref_tmr + 16'h0001;
      end
    end else begin
      s_d.vref     = 8'h00; // RULE22
      s_d.vref_tmr = 16'h0000;
    end

    case (s_q.seq)
      bbsc_pkg::ST_IDLE: begin
        if (all_ok) begin
          s_d.seq = bbsc_pkg::ST_PRECHARGE; // RULE8
        end
      end
      bbsc_pkg::ST_PRECHARGE: begin
        if (input_bootstrap_ok && output_bootstrap_ok) begin
          s_d.seq = bbsc_pkg::ST_SOFTSTART; // RULE10
        end
      end
      bbsc_pkg::ST_SOFTSTART: begin
        if (s_q.vref == vtgt) begin
          s_d.seq = bbsc_pkg::ST_RUN; // RULE22
        end
      end
      bbsc_pkg::ST_RUN: begin
        s_d.seq = bbsc_pkg::ST_RUN;
      end
      default: begin
        s_d.seq = bbsc_pkg::ST_IDLE;
      end
    endcase
    if (!all_ok) begin
      s_d.seq = bbsc_pkg::ST_IDLE;
    end

    // Switch requests per region.
    in_leg.want_high  = 1'b0;
    in_leg.want_low   = 1'b0;
    out_leg.want_high = 1'b0;
    out_leg.want_low  = 1'b0;
    if (s_q.seq == bbsc_pkg::ST_PRECHARGE) begin
      in_leg.want_low  = !current_limit; // RULE8 RULE9
      out_leg.want_low = !current_limit; // RULE8 RULE9
    end else if (switching) begin
      case (s_q.region)
        bbsc_pkg::RG_BOOST: begin
          in_leg.want_high  = 1'b1; // RULE1
          out_leg.want_low  = main_on; // RULE1 RULE2
          out_leg.want_high = !main_on && s_q.rect; // RULE1
        end
        bbsc_pkg::RG_BUCKBOOST: begin
          in_leg.want_high  = main_on;
          in_leg.want_low   = !main_on && s_q.rect;
          out_leg.want_low  = s_q.bb_cnt != 10'h000; // RULE4
          out_leg.want_high = s_q.bb_cnt == 10'h000 && s_q.rect; // RULE4
        end
        bbsc_pkg::RG_BUCK: begin
          in_leg.want_high  = main_on; // RULE3
          in_leg.want_low   = !main_on && s_q.rect; // RULE3
          out_leg.want_high = 1'b1; // RULE3
        end
        default: begin
          in_leg.want_high = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q        <= '0;
      s_q.seq    <= bbsc_pkg::ST_IDLE;
      s_q.region <= bbsc_pkg::RG_BOOST;
      s_q.fbcomp <= bbsc_pkg::FBCOMP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata             = s_q.rdata;
  assign sync_out              = s_q.sync_o;
  assign sync_oe               = sync_out_mode && !sync_in_mode;
  assign input_high_switch     = in_leg.high_on;
  assign input_low_switch      = in_leg.low_on;
  assign output_low_switch     = out_leg.low_on;
  assign output_high_switch    = out_leg.high_on;
  assign vref_code             = s_q.vref;
  assign region                = s_q.region;
  assign precharge_active      = s_q.seq == bbsc_pkg::ST_PRECHARGE;
  assign external_feedback_sel = s_q.fbcomp[bbsc_pkg::FBCOMP_EXT_BIT]; // RULE11
endmodule

// ===== src/leg_driver.sv
// Gate driver for one switch leg with non-overlap dead time.
`timescale 1ns/1ps
module leg_driver (
  input  wire logic clk,
  input  wire logic srst,
  leg_if.drv        leg
);
  typedef struct packed {
    logic [1:0] cur;
    logic [3:0] dead;
  } leg_s;

  leg_s s_q;
  leg_s s_d;
  logic [1:0] req;

  always_comb begin
    s_d = s_q;
    if (leg.want_high && !leg.want_low) begin
      req = 2'h2;
    end else if (leg.want_low && !leg.want_high) begin
      req = 2'h1;
    end else begin
      req = 2'h0;
    end
    if (req != s_q.cur) begin
      if (s_q.cur != 2'h0) begin
        s_d.cur  = 2'h0; // RULE25
        s_d.dead = bbsc_pkg::DEAD_CYC; // RULE25
      end else if (s_q.dead != 4'h0) begin
        s_d.dead = s_q.dead - 4'h1;
      end else begin
        s_d.cur = req;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign leg.high_on = s_q.cur[1];
  assign leg.low_on  = s_q.cur[0];
endmodule

// ===== src/leg_if.sv
// Request and grant signals between the controller and one switch leg driver.
`timescale 1ns/1ps
interface leg_if;
  logic want_high;
  logic want_low;
  logic high_on;
  logic low_on;
  modport ctrl (output want_high, output want_low, input high_on, input low_on);
  modport drv  (input want_high, input want_low, output high_on, output low_on);
endinterface

// ===== test/bbsc_properties.sv
// Concurrent checks on the ports of the buck-boost switch controller.
`timescale 1ns/1ps
module bbsc_properties (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic              enable,
  input wire logic              current_limit,
  input wire logic              input_bootstrap_ok,
  input wire logic              output_bootstrap_ok,
  input wire logic              input_high_switch,
  input wire logic              input_low_switch,
  input wire logic              output_low_switch,
  input wire logic              output_high_switch,
  input wire logic [7:0]        vref_code,
  input wire bbsc_pkg::region_e region,
  input wire logic              precharge_active,
  input wire logic              external_feedback_sel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_in_leg; !(input_high_switch && input_low_switch); endproperty
  a_in_leg: assert property (p_in_leg) else $error("input leg overlap");
  property p_out_leg; !(output_high_switch && output_low_switch); endproperty
  a_out_leg: assert property (p_out_leg) else $error("output leg overlap");
  property p_pre_limit; (precharge_active && current_limit) [*3] |-> !input_low_switch && !output_low_switch; endproperty
  a_pre_limit: assert property (p_pre_limit) else $error("low switches on in limit");
  property p_bst; $fell(precharge_active) && enable |-> $past(input_bootstrap_ok && output_bootstrap_ok); endproperty
  a_bst: assert property (p_bst) else $error("soft start before bootstrap");
  property p_reg_wr; reg_wr && reg_addr == 8'h0d |=> external_feedback_sel == $past(reg_wdata[1]); endproperty
  a_reg_wr: assert property (p_reg_wr) else $error("feedback select not written");
  property p_unmapped; reg_addr != 8'h0d |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_adjacent; $changed(region) |-> region == bbsc_pkg::RG_BUCKBOOST || $past(region) == bbsc_pkg::RG_BUCKBOOST;
  endproperty
  a_adjacent: assert property (p_adjacent) else $error("region skipped");
  property p_vref; $changed(vref_code) && vref_code != 8'h00 |->
    vref_code == $past(vref_code) + 8'h01 || vref_code + 8'h01 == $past(vref_code); endproperty
  a_vref: assert property (p_vref) else $error("reference step not one code");
  property p_out_dead; $fell(output_low_switch) |-> (!output_high_switch) [*3]; endproperty
  a_out_dead: assert property (p_out_dead) else $error("output leg dead time short");
  property p_in_dead; $fell(input_high_switch) |-> (!input_low_switch) [*3]; endproperty
  a_in_dead: assert property (p_in_dead) else $error("input leg dead time short");
endmodule

bind buck_boost_switch_control bbsc_properties u_props (
  .clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .enable, .current_limit, .input_bootstrap_ok,
  .output_bootstrap_ok, .input_high_switch, .input_low_switch, .output_low_switch, .output_high_switch,
  .vref_code, .region, .precharge_active, .external_feedback_sel
);

// ===== test/buck_boost_switch_control_tb.sv
// Self-checking testbench for the buck-boost switch controller.
`timescale 1ns/1ps
module buck_boost_switch_control_tb;
  logic               clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, enable = 1'b0, input_ok = 1'b1, supply_ok = 1'b1;
  logic               sync_in_mode = 1'b0, sync_out_mode = 1'b0, sync_phase_180 = 1'b0, spread_spectrum_en = 1'b0;
  logic               discontinuous_conduction = 1'b0, loop_set = 1'b0, limit_cmd = 1'b0, sync_run = 1'b0;
  logic               zero_cmd = 1'b0;
  logic [7:0]         reg_addr = 8'h0d, reg_wdata = 8'h00, vref_target = 8'h3c, reg_rdata, vref_code;
  logic [11:0]        vin_sense = 12'h3ec, vout_sense = 12'h400;
  logic signed [12:0] bb_rise_off = 13'h000a, bb_fall_off = 13'h0005, buck_rise_off = 13'h0028, buck_fall_off = 13'h0023;
  logic [8:0]         half_period = 9'h032;
  logic [5:0]         spread_spectrum_range = 6'h04;
  logic [15:0]        spread_spectrum_interval = 16'h00c7, softstart_interval = 16'h0001, vref_step_interval = 16'h0004;
  logic [9:0]         on_cycles = 10'h014, bb_duty_cycles = 10'h01e;
  logic               sync_in, sync_out, sync_oe, current_limit, zero_current, reverse_limit, precharge_active;
  logic               input_bootstrap_ok, output_bootstrap_ok, external_feedback_sel;
  logic               input_high_switch, input_low_switch, output_low_switch, output_high_switch;
  bbsc_pkg::region_e  region;
  int                 bad_count = 0;
  int                 total_checks = 0;

  always #5 clk = ~clk;

  buck_boost_switch_control dut (
    .clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .input_ok, .supply_ok, .enable, .vin_sense,
    .vout_sense, .bb_rise_off, .bb_fall_off, .buck_rise_off, .buck_fall_off, .half_period, .sync_in_mode,
    .sync_out_mode, .sync_phase_180, .sync_in, .sync_out, .sync_oe, .spread_spectrum_en, .spread_spectrum_range,
    .spread_spectrum_interval, .discontinuous_conduction, .loop_set, .zero_current, .reverse_limit,
    .current_limit, .input_bootstrap_ok, .output_bootstrap_ok, .on_cycles, .bb_duty_cycles, .vref_target,
    .softstart_interval, .vref_step_interval, .input_high_switch, .input_low_switch, .output_low_switch,
    .output_high_switch, .vref_code, .region, .precharge_active, .external_feedback_sel
  );
  power_stage_model stage (
    .clk, .input_low_switch, .output_low_switch, .limit_cmd, .zero_cmd, .sync_run, .current_limit, .zero_current,
    .reverse_limit, .input_bootstrap_ok, .output_bootstrap_ok, .sync_in
  );

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask
  function automatic logic pick(bit sel);
    return sel ? sync_out : output_low_switch;
  endfunction
  task automatic run_len(input bit sel, input logic lvl, output int n);
    for (n = 0; n < 900 && pick(sel) === lvl; n++) tick();
    for (n = 0; n < 900 && pick(sel) !== lvl; n++) tick();
    for (n = 0; n < 900 && pick(sel) === lvl; n++) tick();
  endtask
  task automatic step_gap(int exp);
    int n;
    logic [7:0] v;
    v = vref_code;
    for (n = 0; n < 100 && vref_code === v; n++) tick();
    v = vref_code;
    for (n = 0; n < 100 && vref_code === v; n++) tick();
    check("step_gap", n[15:0], exp[15:0]);
  endtask
  task automatic settle(string name, logic [7:0] t);
    for (int i = 0; i < 2000 && vref_code !== t; i++) tick();
    tick(20);
    check(name, vref_code, t);
  endtask

  task automatic test_reg();
    check("rd_rst", reg_rdata, 8'h00);
    wr(8'h0d, 8'h02);
    check("sel_set", external_feedback_sel, 1'b1);
    check("rd_0d", reg_rdata, 8'h02);
    wr(8'h0e, 8'h00);
    check("sel_keep", external_feedback_sel, 1'b1);
    check("rd_0e", reg_rdata, 8'h00);
    wr(8'h0d, 8'hfd);
    check("sel_clr", external_feedback_sel, 1'b0);
  endtask
  task automatic test_start();
    enable = 1'b1;
    for (int i = 0; i < 20 && precharge_active !== 1'b1; i++) tick();
    tick(4);
    check("pre_low", {input_low_switch, output_low_switch}, 2'b11);
    limit_cmd = 1'b1;
    tick(4);
    check("lim_off", {input_low_switch, output_low_switch}, 2'b00);
    limit_cmd = 1'b0;
    tick(6);
    check("lim_on", {input_low_switch, output_low_switch}, 2'b11);
    for (int i = 0; i < 200 && precharge_active !== 1'b0; i++) tick();
    check("ss_zero", vref_code, 8'h00);
    step_gap(2);
    settle("ss_end", 8'h3c);
  endtask
  task automatic test_vref();
    vref_target = 8'h37;
    step_gap(5);
    settle("vref_dn", 8'h37);
    vref_target = 8'hfa;
    settle("clamp_hi", 8'hc8);
    vref_target = 8'h10;
    settle("clamp_lo", 8'h32);
  endtask
  task automatic test_sync();
    int n;
    sync_out_mode = 1'b1;
    tick();
    check("oe_on", sync_oe, 1'b1);
    for (int i = 0; i < 4; i++) begin
      half_period = i[0] ? 9'h0fa : 9'h032;
      sync_phase_180 = i[1];
      tick(600);
      run_len(1'b1, 1'b1, n);
      check("sync_hi", n[15:0], {7'h00, half_period});
      run_len(1'b1, 1'b0, n);
      check("sync_lo", n[15:0], {7'h00, half_period});
      sync_phase_180 = !i[1];
      tick();
      check("sync_ph", sync_out, 1'b0);
    end
    half_period = 9'h032;
  endtask
  task automatic test_spread();
    int n;
    int lo = 999;
    int hi = 0;
    spread_spectrum_en = 1'b1;
    repeat (40) begin
      run_len(1'b1, 1'b1, n);
      lo = (n < lo) ? n : lo;
      hi = (n > hi) ? n : hi;
    end
    check("ss_max", hi[15:0], 16'h0036);
    check("ss_min", lo[15:0], 16'h002e);
    sync_in_mode = 1'b1;
    sync_run = 1'b1;
    half_period = 9'h0fa;
    tick(300);
    check("oe_off", sync_oe, 1'b0);
    sync_in_mode = 1'b0;
    sync_run = 1'b0;
    half_period = 9'h032;
    run_len(1'b1, 1'b1, n);
    check("ss_sync", n[15:0], 16'h0036);
    spread_spectrum_en = 1'b0;
  endtask
  task automatic test_dcm();
    int n;
    discontinuous_conduction = 1'b1;
    zero_cmd = 1'b1;
    tick(300);
    check("dcm_idle", {output_high_switch, output_low_switch}, 2'b00);
    loop_set = 1'b1;
    tick();
    loop_set = 1'b0;
    tick(5);
    check("dcm_set", output_low_switch, 1'b1);
    tick(40);
    check("dcm_rect", {output_high_switch, output_low_switch}, 2'b00);
    discontinuous_conduction = 1'b0;
    run_len(1'b0, 1'b1, n);
    tick(5);
    check("forced_continuous_conduction_rect", output_high_switch, 1'b1);
    zero_cmd = 1'b0;
  endtask
  task automatic test_region();
    int n;
    logic [12:0] diff [9] = '{13'h1fec, 13'h0007, 13'h000c, 13'h0007, 13'h002d, 13'h0025, 13'h0014, 13'h0000, 13'h0032};
    logic [2:0] exp [9] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h2, 3'h1, 3'h4};
    for (int i = 0; i < 9; i++) begin
      vin_sense = vout_sense + 12'(diff[i]);
      tick(300);
      check("region", region, exp[i]);
      if (exp[i] == 3'h1) begin
        check("boost_leg", {input_high_switch, input_low_switch}, 2'b10);
        run_len(1'b0, 1'b1, n);
        check("boost_on", n[15:0], on_cycles - 10'(bbsc_pkg::DEAD_CYC) - 10'h001);
      end else if (exp[i] == 3'h4) begin
        check("buck_leg", {output_high_switch, output_low_switch}, 2'b10);
      end else begin
        run_len(1'b0, 1'b1, n);
        check("bb_on", n[15:0], bb_duty_cycles - 10'(bbsc_pkg::DEAD_CYC) - 10'h001);
      end
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #600000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    tick();
    test_reg();
    test_start();
    test_vref();
    test_sync();
    test_spread();
    test_dcm();
    test_region();
    final_report();
  end
endmodule

// ===== test/power_stage_model.sv
// Behavioural power stage: bootstrap charging, current comparators and an external sync clock.
`timescale 1ns/1ps
module power_stage_model #(
  parameter int CHARGE_CYC   = 40,
  parameter int SYNC_HALF_NS = 800
) (
  input  wire logic clk,
  input  wire logic input_low_switch,
  input  wire logic output_low_switch,
  input  wire logic limit_cmd,
  input  wire logic zero_cmd,
  input  wire logic sync_run,
  output logic      current_limit,
  output logic      zero_current,
  output logic      reverse_limit,
  output logic      input_bootstrap_ok,
  output logic      output_bootstrap_ok,
  output logic      sync_in
);
  int   charge_q = 0;
  logic sync_q   = 1'b0;
  always @(posedge clk) begin
    if (input_low_switch && output_low_switch && charge_q < CHARGE_CYC) begin
      charge_q <= charge_q + 1;
    end
  end
  assign input_bootstrap_ok  = (charge_q >= CHARGE_CYC);
  assign output_bootstrap_ok = (charge_q >= CHARGE_CYC);
  assign current_limit       = limit_cmd;
  assign zero_current        = zero_cmd;
  assign reverse_limit       = 1'b0;
  always begin
    #(SYNC_HALF_NS);
    sync_q = sync_run ? ~sync_q : 1'b0;
  end
  assign sync_in = sync_q;
endmodule
